// ===== src/lpa_exec.v
// Execution datapath for logical AND and selector privilege adjust
`timescale 1ns/10ps
`default_nettype none
`include "lpa_defs.vh"

module lpa_exec (
   // Clock and reset
   input  wire        clk,
   input  wire        rst,
   // Instruction from decode
   input  wire        issue_valid,
   input  wire [7:0]  opcode,
   input  wire [7:0]  modrm,
   input  wire        opsize32,
   // Operands
   input  wire [31:0] dest_value,
   input  wire [31:0] src_reg_value,
   input  wire [31:0] src_mem_value,
   input  wire [31:0] imm_value,
   // Processor state
   input  wire [1:0]  cpu_mode,
   input  wire [1:0]  cur_priv,
   input  wire        align_check_en,
   // Memory access checks
   input  wire        mem_access,
   input  wire        mem_unaligned,
   input  wire        seg_not_writable,
   input  wire        data_limit_viol,
   input  wire        stack_limit_viol,
   input  wire        data_seg_null,
   input  wire        paging_fault,
   input  wire [15:0] paging_fault_code,
   // Result
   output reg         done_q,
   output reg         wb_en_q,
   output reg         wb_to_mem_q,
   output reg  [31:0] result_q,
   output reg  [1:0]  result_size_q,
   // Flags
   output reg         flags_we_q,
   output reg         overflow_flag_q,
   output reg         carry_flag_q,
   output reg         sign_flag_q,
   output reg         zero_flag_q,
   output reg         parity_flag_q,
   output reg         aux_carry_flag_q,
   output reg         zero_only_q,
   // Faults
   output reg  [2:0]  fault_kind_q,
   output reg         fault_has_code_q,
   output reg  [15:0] fault_code_q
);

   // ****************************************
   // Decode
   // ****************************************
   reg        is_and;
   reg        is_spa;
   reg        and_imm;
   reg        and_rm_src;
   reg        and_to_reg;
   reg        sx_imm;
   reg [1:0]  size;
   wire       rm_is_reg = (modrm[7:6] == `LPA_MODRM_REG_MOD);
   wire [1:0] wide_sz   = opsize32 ? `LPA_SZ_32 : `LPA_SZ_16;

   always @* begin
      is_and     = 1'b0;
      is_spa     = 1'b0;
      and_imm    = 1'b0;
      and_rm_src = 1'b0;
      and_to_reg = 1'b0;
      sx_imm     = 1'b0;
      size       = wide_sz;
      case (opcode)
         `LPA_OP_AND_AL_I: begin
            is_and     = 1'b1;
            and_imm    = 1'b1;
            and_to_reg = 1'b1;
            size       = `LPA_SZ_8;
         end
         `LPA_OP_AND_AX_I: begin
            is_and     = 1'b1;
            and_imm    = 1'b1;
            and_to_reg = 1'b1;
         end
         `LPA_OP_GRP1_8: begin
            is_and  = (modrm[5:3] == `LPA_GRP1_AND_REG);
            and_imm = 1'b1;
            size    = `LPA_SZ_8;
         end
         `LPA_OP_GRP1_W: begin
            is_and  = (modrm[5:3] == `LPA_GRP1_AND_REG);
            and_imm = 1'b1;
         end
         `LPA_OP_GRP1_SX: begin
            is_and  = (modrm[5:3] == `LPA_GRP1_AND_REG);
            and_imm = 1'b1;
            sx_imm  = 1'b1;
         end
         `LPA_OP_AND_RM8_R: begin
            is_and = 1'b1;
            size   = `LPA_SZ_8;
         end
         `LPA_OP_AND_RM_R: begin
            is_and = 1'b1;
         end
         `LPA_OP_AND_R8_RM: begin
            is_and     = 1'b1;
            and_rm_src = 1'b1;
            and_to_reg = 1'b1;
            size       = `LPA_SZ_8;
         end
         `LPA_OP_AND_R_RM: begin
            is_and     = 1'b1;
            and_rm_src = 1'b1;
            and_to_reg = 1'b1;
         end
         `LPA_OP_SPA: begin
            is_spa = 1'b1;
            size   = `LPA_SZ_16;
         end
         default: begin
            is_and = 1'b0;
         end
      endcase
   end

   // ****************************************
   // Logical AND datapath
   // ****************************************
   reg [31:0] src_op;

   always @* begin
      if (and_imm) begin
         if (sx_imm) begin
            src_op = {{24{imm_value[7]}}, imm_value[7:0]};
         end else begin
            src_op = imm_value;
         end
      end else if (and_rm_src && !rm_is_reg) begin
         src_op = src_mem_value;
      end else begin
         src_op = src_reg_value;
      end
   end

   wire [31:0] and_raw = dest_value & src_op;
   reg  [31:0] and_res;

   always @* begin
      case (size)
         `LPA_SZ_8:  and_res = {24'h00_0000, and_raw[7:0]};
         `LPA_SZ_16: and_res = {16'h0000, and_raw[15:0]};
         default:    and_res = and_raw;
      endcase
   end

   wire fl_sign;
   wire fl_zero;
   wire fl_par;

   lpa_flag_gen u_flags (
      .result      (and_res),
      .size        (size),
      .sign_flag   (fl_sign),
      .zero_flag   (fl_zero),
      .parity_flag (fl_par)
   );

   // ****************************************
   // Selector privilege adjust datapath
   // ****************************************
   // Source always a 16-bit register
   wire [15:0] spa_src  = src_reg_value[15:0];
   wire [15:0] spa_dst  = dest_value[15:0];
   wire        spa_lower = spa_dst[`LPA_RPF_HI:`LPA_RPF_LO] < spa_src[`LPA_RPF_HI:`LPA_RPF_LO];
   wire [15:0] spa_res  = {spa_dst[15:2], spa_src[`LPA_RPF_HI:`LPA_RPF_LO]};

   // ****************************************
   // Fault checks
   // ****************************************
   reg [2:0]  flt;
   reg        flt_code;
   reg [15:0] flt_val;
   wire       dst_mem = !rm_is_reg && !(is_and && and_to_reg);
   wire       mode_pm = (cpu_mode == `LPA_MODE_PROT);
   wire       mode_rm = (cpu_mode == `LPA_MODE_REAL);
   wire       mode_vm = (cpu_mode == `LPA_MODE_V86);

   always @* begin
      flt      = `LPA_FLT_NONE;
      flt_code = 1'b0;
      flt_val  = `LPA_ERR_ZERO;
      if (is_spa && !mode_pm) begin
         flt = `LPA_FLT_UD;
      end else if (mem_access) begin
         if (mode_pm && (data_seg_null || data_limit_viol || (dst_mem && seg_not_writable))) begin
            flt      = `LPA_FLT_GP;
            flt_code = 1'b1;
         end else if (!mode_pm && data_limit_viol) begin
            // Real mode has no code; v86 pushes zero
            flt      = `LPA_FLT_GP;
            flt_code = mode_vm;
         end else if (stack_limit_viol) begin
            // Stack fault, no code in real mode
            flt      = `LPA_FLT_SS;
            flt_code = !mode_rm;
         end else if (!mode_rm && paging_fault) begin
            flt      = `LPA_FLT_PF;
            flt_code = 1'b1;
            flt_val  = paging_fault_code;
         end else if (mem_unaligned && align_check_en &&
                      (mode_vm || (mode_pm && cur_priv == `LPA_CPL_USER))) begin
            flt      = `LPA_FLT_AC;
            flt_code = 1'b1;
         end
      end
   end

   // ****************************************
   // Next result values
   // ****************************************
   wire       go      = issue_valid && (is_and || is_spa);
   wire       go_good = go && (flt == `LPA_FLT_NONE);

   reg        done_d;
   reg        wb_en_d;
   reg        wb_to_mem_d;
   reg [31:0] result_d;
   reg [1:0]  result_size_d;
   reg        flags_we_d;
   reg        overflow_flag_d;
   reg        carry_flag_d;
   reg        sign_flag_d;
   reg        zero_flag_d;
   reg        parity_flag_d;
   reg        aux_carry_flag_d;
   reg        zero_only_d;
   reg [2:0]  fault_kind_d;
   reg        fault_has_code_d;
   reg [15:0] fault_code_d;

   always @* begin
      // Pulses drop, results and flags hold
      done_d           = go;
      wb_en_d          = 1'b0;
      wb_to_mem_d      = wb_to_mem_q;
      result_d         = result_q;
      result_size_d    = result_size_q;
      flags_we_d       = 1'b0;
      overflow_flag_d  = overflow_flag_q;
      carry_flag_d     = carry_flag_q;
      sign_flag_d      = sign_flag_q;
      zero_flag_d      = zero_flag_q;
      parity_flag_d    = parity_flag_q;
      aux_carry_flag_d = aux_carry_flag_q;
      zero_only_d      = 1'b0;
      fault_kind_d     = go ? flt : `LPA_FLT_NONE;
      fault_has_code_d = go && flt_code;
      fault_code_d     = go ? flt_val : `LPA_ERR_ZERO;
      if (go_good) begin
         wb_to_mem_d   = dst_mem;
         result_size_d = size;
         flags_we_d    = 1'b1;
         if (is_and) begin
            wb_en_d          = 1'b1;
            result_d         = and_res;
            overflow_flag_d  = 1'b0;
            carry_flag_d     = 1'b0;
            sign_flag_d      = fl_sign;
            zero_flag_d      = fl_zero;
            parity_flag_d    = fl_par;
            aux_carry_flag_d = 1'b0;
         end else begin
            // Zero flag only; write only if raised
            zero_only_d = 1'b1;
            zero_flag_d = spa_lower;
            wb_en_d     = spa_lower;
            result_d    = {16'h0000, spa_lower ? spa_res : spa_dst};
         end
      end
   end

   // ****************************************
   // Result registers
   // ****************************************

   always @(posedge clk) begin
      if (rst) begin
         done_q           <= 1'b0;
         wb_en_q          <= 1'b0;
         wb_to_mem_q      <= 1'b0;
         result_q         <= 32'h0000_0000;
         result_size_q    <= `LPA_SZ_8;
         flags_we_q       <= 1'b0;
         overflow_flag_q  <= 1'b0;
         carry_flag_q     <= 1'b0;
         sign_flag_q      <= 1'b0;
         zero_flag_q      <= 1'b0;
         parity_flag_q    <= 1'b0;
         aux_carry_flag_q <= 1'b0;
         zero_only_q      <= 1'b0;
         fault_kind_q     <= `LPA_FLT_NONE;
         fault_has_code_q <= 1'b0;
         fault_code_q     <= `LPA_ERR_ZERO;
      end else begin
         done_q           <= done_d;
         wb_en_q          <= wb_en_d;
         wb_to_mem_q      <= wb_to_mem_d;
         result_q         <= result_d;
         result_size_q    <= result_size_d;
         flags_we_q       <= flags_we_d;
         overflow_flag_q  <= overflow_flag_d;
         carry_flag_q     <= carry_flag_d;
         sign_flag_q      <= sign_flag_d;
         zero_flag_q      <= zero_flag_d;
         parity_flag_q    <= parity_flag_d;
         aux_carry_flag_q <= aux_carry_flag_d;
         zero_only_q      <= zero_only_d;
         fault_kind_q     <= fault_kind_d;
         fault_has_code_q <= fault_has_code_d;
         fault_code_q     <= fault_code_d;
      end
   end

endmodule // lpa_exec
`default_nettype wire

// ===== pkg/lpa_defs.vh
// Constants for the logic and privilege adjust datapath
`ifndef LPA_DEFS_VH
`define LPA_DEFS_VH

// ****************************************
// Operating modes
// ****************************************
`define LPA_MODE_REAL     2'h0
`define LPA_MODE_PROT     2'h1
`define LPA_MODE_V86      2'h2

// ****************************************
// Operand sizes
// ****************************************
`define LPA_SZ_8          2'h0
`define LPA_SZ_16         2'h1
`define LPA_SZ_32         2'h2

// ****************************************
// Opcodes
// ****************************************
`define LPA_OP_AND_RM8_R  8'h20
`define LPA_OP_AND_RM_R   8'h21
`define LPA_OP_AND_R8_RM  8'h22
`define LPA_OP_AND_R_RM   8'h23
`define LPA_OP_AND_AL_I   8'h24
`define LPA_OP_AND_AX_I   8'h25
`define LPA_OP_GRP1_8     8'h80
`define LPA_OP_GRP1_W     8'h81
`define LPA_OP_GRP1_SX    8'h83
`define LPA_OP_SPA        8'h63
`define LPA_GRP1_AND_REG  3'h4
`define LPA_MODRM_REG_MOD 2'h3

// ****************************************
// Fault kinds
// ****************************************
`define LPA_FLT_NONE      3'h0
`define LPA_FLT_GP        3'h1
`define LPA_FLT_SS        3'h2
`define LPA_FLT_PF        3'h3
`define LPA_FLT_AC        3'h4
`define LPA_FLT_UD        3'h5

// ****************************************
// Field positions and values
// ****************************************
`define LPA_RPF_HI        1
`define LPA_RPF_LO        0
`define LPA_CPL_USER      2'h3
`define LPA_ERR_ZERO      16'h0000

`endif

// ===== src/lpa_flag_gen.v
// Result flag generator for the logical AND
`timescale 1ns/10ps
`default_nettype none
`include "lpa_defs.vh"

module lpa_flag_gen (
   // Result and size
   input  wire [31:0] result,
   input  wire [1:0]  size,
   // Flags
   output reg         sign_flag,
   output reg         zero_flag,
   output wire        parity_flag
);

   // Parity looks at the low byte only, even parity sets
   assign parity_flag = ~^result[7:0];

   always @* begin
      case (size)
         `LPA_SZ_8: begin
            sign_flag = result[7];
            zero_flag = (result[7:0] == 8'h00);
         end
         `LPA_SZ_16: begin
            sign_flag = result[15];
            zero_flag = (result[15:0] == 16'h0000);
         end
         default: begin
            sign_flag = result[31];
            zero_flag = (result == 32'h0000_0000);
         end
      endcase
   end

endmodule // lpa_flag_gen
`default_nettype wire

// ===== verification/lpa_exec_assertions.sv
// Concurrent checks on the logic and privilege adjust datapath ports
`timescale 1ns/10ps
`default_nettype none
`include "lpa_defs.vh"

module lpa_exec_assertions (
   // Clock and reset
   input wire logic        clk,
   input wire logic        rst,
   // Instruction and state
   input wire logic        issue_valid,
   input wire logic [7:0]  opcode,
   input wire logic [7:0]  modrm,
   input wire logic [1:0]  cpu_mode,
   input wire logic [1:0]  cur_priv,
   input wire logic        mem_access,
   input wire logic        mem_unaligned,
   input wire logic        align_check_en,
   input wire logic        data_limit_viol,
   input wire logic        stack_limit_viol,
   input wire logic        data_seg_null,
   input wire logic        paging_fault,
   input wire logic [15:0] paging_fault_code,
   input wire logic [31:0] dest_value,
   input wire logic [31:0] src_reg_value,
   // Results and faults
   input wire logic        done_q,
   input wire logic        wb_en_q,
   input wire logic        flags_we_q,
   input wire logic        zero_only_q,
   input wire logic        overflow_flag_q,
   input wire logic        carry_flag_q,
   input wire logic        zero_flag_q,
   input wire logic        parity_flag_q,
   input wire logic [31:0] result_q,
   input wire logic [1:0]  result_size_q,
   input wire logic [2:0]  fault_kind_q,
   input wire logic        fault_has_code_q,
   input wire logic [15:0] fault_code_q
);
   wire spa = opcode == `LPA_OP_SPA;
   wire [1:0] dst_field = dest_value[`LPA_RPF_HI:`LPA_RPF_LO];
   wire [1:0] src_field = src_reg_value[`LPA_RPF_HI:`LPA_RPF_LO];
   wire acc = issue_valid && (spa || opcode inside {[8'h20:8'h25]} ||
              (opcode inside {8'h80, 8'h81, 8'h83} && modrm[5:3] == `LPA_GRP1_AND_REG));

   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   // ****************************************
   // Assertions
   // ****************************************
   a_issue_done: assert property (acc |=> done_q)
      else $error("accepted issue gave no done");
   a_refused_idle: assert property (!acc |=> !done_q && !wb_en_q && !flags_we_q)
      else $error("ignored opcode produced output");
   a_and_clears: assert property (flags_we_q && !zero_only_q |-> !overflow_flag_q && !carry_flag_q)
      else $error("overflow or carry set after and");
   a_and_flags: assert property (flags_we_q && !zero_only_q |->
      parity_flag_q == ~^result_q[7:0] && zero_flag_q == (result_q == 32'h0000_0000))
      else $error("parity or zero wrong after and");
   a_adjust_zero: assert property (zero_only_q |-> zero_flag_q == wb_en_q && result_size_q == `LPA_SZ_16)
      else $error("adjust zero flag and writeback disagree");
   a_adjust_compare: assert property (issue_valid && spa && cpu_mode == `LPA_MODE_PROT && !mem_access |=>
      zero_only_q && zero_flag_q == ($past(dst_field) < $past(src_field)))
      else $error("adjust field compare wrong");
   a_adjust_ud: assert property (issue_valid && spa && cpu_mode != `LPA_MODE_PROT |=>
      fault_kind_q == `LPA_FLT_UD)
      else $error("adjust outside protected mode not refused");
   a_null_selector: assert property (acc && mem_access && cpu_mode == `LPA_MODE_PROT && data_seg_null |=>
      fault_kind_q == `LPA_FLT_GP && fault_has_code_q && fault_code_q == `LPA_ERR_ZERO)
      else $error("null selector not refused");
   a_real_nocode: assert property (acc && cpu_mode == `LPA_MODE_REAL ##1
      fault_kind_q inside {`LPA_FLT_GP, `LPA_FLT_SS} |-> !fault_has_code_q)
      else $error("real mode fault carried a code");
   a_pf_code: assert property (acc ##1 fault_kind_q == `LPA_FLT_PF |->
      fault_has_code_q && fault_code_q == $past(paging_fault_code))
      else $error("page fault code wrong");
   a_ac_priv: assert property (acc && mem_access && cpu_mode == `LPA_MODE_PROT &&
      cur_priv != `LPA_CPL_USER |=> fault_kind_q != `LPA_FLT_AC)
      else $error("alignment fault below user privilege");
   a_v86_align: assert property (acc && !spa && cpu_mode == `LPA_MODE_V86 &&
      mem_access && align_check_en && mem_unaligned && !data_limit_viol && !stack_limit_viol && !paging_fault |=>
      fault_kind_q == `LPA_FLT_AC && fault_has_code_q)
      else $error("virtual-8086 alignment fault missing");
   a_fault_blocks: assert property (fault_kind_q != `LPA_FLT_NONE |-> done_q && !wb_en_q && !flags_we_q)
      else $error("faulted instruction wrote back");

   c_adjust_raise: cover property (zero_only_q && wb_en_q);
   c_back_to_back: cover property (done_q ##1 done_q);
   c_align_fault: cover property (fault_kind_q == `LPA_FLT_AC);
endmodule // lpa_exec_assertions

bind lpa_exec lpa_exec_assertions i_chk (
   .clk               (clk),
   .rst               (rst),
   .issue_valid       (issue_valid),
   .opcode            (opcode),
   .modrm             (modrm),
   .cpu_mode          (cpu_mode),
   .cur_priv          (cur_priv),
   .mem_access        (mem_access),
   .mem_unaligned     (mem_unaligned),
   .align_check_en    (align_check_en),
   .data_limit_viol   (data_limit_viol),
   .stack_limit_viol  (stack_limit_viol),
   .data_seg_null     (data_seg_null),
   .paging_fault      (paging_fault),
   .paging_fault_code (paging_fault_code),
   .dest_value        (dest_value),
   .src_reg_value     (src_reg_value),
   .done_q            (done_q),
   .wb_en_q           (wb_en_q),
   .flags_we_q        (flags_we_q),
   .zero_only_q       (zero_only_q),
   .overflow_flag_q   (overflow_flag_q),
   .carry_flag_q      (carry_flag_q),
   .zero_flag_q       (zero_flag_q),
   .parity_flag_q     (parity_flag_q),
   .result_q          (result_q),
   .result_size_q     (result_size_q),
   .fault_kind_q      (fault_kind_q),
   .fault_has_code_q  (fault_has_code_q),
   .fault_code_q      (fault_code_q)
);

`default_nettype wire

// ===== verification/tb_logic_and_privilege_adjust.sv
// Self-checking bench for the logic and privilege adjust datapath
`timescale 1ns/10ps
`default_nettype none
`include "lpa_defs.vh"

module tb_logic_and_privilege_adjust;
   logic        clk = '0, rst = '1, issue_valid = '0, opsize32 = '0, align_check_en = '0;
   logic [7:0]  opcode = '0, modrm = '0;
   logic [31:0] dest_value = '0, src_reg_value = '0, src_mem_value = '0, imm_value = '0;
   logic [1:0]  cpu_mode = '0, cur_priv = '0;
   logic        mem_access = '0, mem_unaligned = '0, seg_not_writable = '0, data_limit_viol = '0;
   logic        stack_limit_viol = '0, data_seg_null = '0, paging_fault = '0;
   logic [15:0] paging_fault_code = '0;
   wire         done_q, wb_en_q, wb_to_mem_q, flags_we_q, overflow_flag_q, carry_flag_q;
   wire         sign_flag_q, zero_flag_q, parity_flag_q, zero_only_q, fault_has_code_q;
   wire [31:0]  result_q;
   wire [1:0]   result_size_q;
   wire [2:0]   fault_kind_q;
   wire [15:0]  fault_code_q;
   logic        e_acc, e_wb, e_mem, e_adj, e_has, e_sf, e_zf;
   logic [31:0] e_res;
   logic [1:0]  e_sz;
   logic [2:0]  e_flt;
   logic [15:0] e_code;
   int          bad_count = 0, checked = 0, cycles = 0;

   lpa_exec i_dut (.*, .aux_carry_flag_q());

   always #2.5 clk = ~clk;

   // ****************************************
   // Checking and verdict
   // ****************************************
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      checked++;
      if (seen !== want) begin
         bad_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 4000) begin
         bad_count++;
         print_verdict();
      end
   end

   // Expected outcome of the instruction now on the inputs
   function automatic void predict();
      logic [31:0] src, msk;
      e_adj = opcode == `LPA_OP_SPA;
      e_acc = issue_valid && (e_adj || opcode inside {[8'h20:8'h25]} ||
              (opcode inside {8'h80, 8'h81, 8'h83} && modrm[5:3] == 3'h4));
      e_sz = opcode inside {8'h20, 8'h22, 8'h24, 8'h80} ? `LPA_SZ_8 : opsize32 && !e_adj ? `LPA_SZ_32 : `LPA_SZ_16;
      msk = e_sz == `LPA_SZ_8 ? 32'h0000_00ff : e_sz == `LPA_SZ_16 ? 32'h0000_ffff : 32'hffff_ffff;
      src = opcode inside {8'h20, 8'h21} || modrm[7:6] == 2'h3 ? src_reg_value : src_mem_value;
      if (opcode inside {8'h24, 8'h25, 8'h80, 8'h81}) src = imm_value;
      if (opcode == `LPA_OP_GRP1_SX) src = {{24{imm_value[7]}}, imm_value[7:0]};
      e_res = dest_value & src & msk;
      e_sf = e_res[e_sz == `LPA_SZ_8 ? 7 : e_sz == `LPA_SZ_16 ? 15 : 31];
      e_zf = e_res == 32'h0000_0000;
      e_mem = modrm[7:6] != 2'h3 && !(opcode inside {[8'h22:8'h25]});
      e_wb = 1'b1;
      if (e_adj) begin
         e_zf = dest_value[1:0] < src_reg_value[1:0];
         e_wb = e_zf;
         e_res = {16'h0000, dest_value[15:2], e_zf ? src_reg_value[1:0] : dest_value[1:0]};
      end
      e_flt = `LPA_FLT_NONE;
      e_has = cpu_mode != `LPA_MODE_REAL;
      e_code = `LPA_ERR_ZERO;
      if (e_adj && cpu_mode != `LPA_MODE_PROT) e_flt = `LPA_FLT_UD;
      else if (mem_access) begin
         if (data_limit_viol || cpu_mode == `LPA_MODE_PROT && (data_seg_null || seg_not_writable && e_mem))
            e_flt = `LPA_FLT_GP;
         else if (stack_limit_viol) e_flt = `LPA_FLT_SS;
         else if (paging_fault && cpu_mode != `LPA_MODE_REAL) begin
            e_flt = `LPA_FLT_PF;
            e_code = paging_fault_code;
         end else if (mem_unaligned && align_check_en && (cpu_mode == `LPA_MODE_V86 ||
                  cpu_mode == `LPA_MODE_PROT && cur_priv == `LPA_CPL_USER))
            e_flt = `LPA_FLT_AC;
      end
   endfunction

   task automatic verify();
      check(done_q, e_acc);
      check(fault_kind_q, e_acc ? e_flt : `LPA_FLT_NONE);
      if (e_acc && e_flt != `LPA_FLT_NONE && e_flt != `LPA_FLT_UD) begin
         check({fault_has_code_q, fault_code_q}, {e_has, e_code});
      end
      if (e_acc && e_flt == `LPA_FLT_NONE) begin
         check(wb_en_q, e_wb);
         check(result_q, e_res);
         check(result_size_q, e_sz);
         check(wb_to_mem_q, e_mem);
         check({flags_we_q, zero_only_q, zero_flag_q}, {1'b1, e_adj, e_zf});
         if (!e_adj) check({overflow_flag_q, carry_flag_q, sign_flag_q, parity_flag_q},
                           {2'b00, e_sf, ~^e_res[7:0]});
      end else check({wb_en_q, flags_we_q}, 2'b00);
   endtask

   // ****************************************
   // Stimulus
   // ****************************************
   task automatic drive(input int i);
      logic [7:0]  ops [12] = '{8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h80, 8'h81, 8'h83, 8'h63, 8'h00, 8'h62};
      logic [31:0] r;
      r = $urandom;
      issue_valid = r[31:29] != 3'h0;
      opcode = ops[$urandom % 12];
      cpu_mode = 2'($urandom % 3);
      {modrm, cur_priv, align_check_en, opsize32} = 12'($urandom);
      {dest_value, src_reg_value, src_mem_value, imm_value} = {$urandom, $urandom, $urandom, $urandom};
      {mem_unaligned, paging_fault_code} = 17'($urandom);
      {seg_not_writable, data_limit_viol, stack_limit_viol, data_seg_null, paging_fault} =
         {&r[2:0], &r[5:3], &r[8:6], &r[11:9], &r[14:12]};
      // Sign extension of a negative byte immediate
      if (i % 8 == 1) begin
         opcode = `LPA_OP_GRP1_SX;
         modrm = 8'he0;
         imm_value = 32'h0000_0080;
      end
      if (i % 8 == 2) dest_value = 32'h0000_0000;
      // Equal privilege fields leave the selector alone
      if (i % 8 == 3) begin
         opcode = `LPA_OP_SPA;
         cpu_mode = `LPA_MODE_PROT;
         src_reg_value[1:0] = dest_value[1:0];
      end
      mem_access = modrm[7:6] != 2'h3 && !(opcode inside {8'h24, 8'h25});
   endtask

   initial begin
      void'($urandom(37));
      e_acc = 1'b0;
      repeat (6) @(posedge clk);
      for (int i = 0; i < 2000; i++) begin
         #1 rst = 1'b0;
         verify();
         drive(i);
         predict();
         @(posedge clk);
      end
      #1 verify();
      print_verdict();
   end
endmodule // tb_logic_and_privilege_adjust

`default_nettype wire
